// ---- iwd_top.v ----
// Operation
// - Watchdog count is a 12-bit counter decremented on every prescaled tick.
// - An 8-bit prescaler divides the watchdog clock before the counter.
// - Prescaler is clocked by a dedicated nominal 40 kHz oscillator tick.
// - Counting continues in Stop and Standby states.
// - Expiry either resets the device or just flags a timeout.
// - Non-volatile option chooses hardware start or software start.
// - Counter holds its value while the core is halted under debug freeze.
// - Watchdog reset acts as a wakeup source that ends Standby.
`timescale 1ns/10ps
`include "iwd_defs.vh"

module iwd_top (
	// Clock and reset
	input  wire                  CORE_CLK_IN,
	input  wire                  RSTN_IN,
	// Option and mode inputs
	input  wire                  HW_START_OPT_IN,
	input  wire                  RESET_MODE_IN,
	input  wire                  DBG_FREEZE_IN,
	input  wire                  CORE_HALTED_IN,
	input  wire                  STOP_MODE_IN,
	input  wire                  STANDBY_MODE_IN,
	// Software control
	input  wire                  SW_START_IN,
	input  wire                  RELOAD_IN,
	input  wire [`IWD_CNT_W-1:0] RELOAD_VAL_IN,
	input  wire [`IWD_PRE_W-1:0] PRESCALE_IN,
	// Status and reset outputs
	output reg  [`IWD_CNT_W-1:0] COUNT_OUT,
	output reg                   RUNNING_OUT,
	output reg                   TIMEOUT_OUT,
	output reg                   SYS_RESET_REQ_OUT,
	output reg                   STANDBY_WAKE_OUT
);

	// ----------------------------------------
	// Oscillator tick source
	// ----------------------------------------
	wire                  osc_tick;
	reg  [1:0]            state_q;
	reg  [1:0]            state_d;
	reg  [`IWD_PRE_W-1:0] pre_q;
	reg                   opt_seen_q;
	wire                  frozen;
	wire                  pre_wrap;

	iwd_lsi_osc u_osc (
		.CORE_CLK_IN (CORE_CLK_IN),
		.RSTN_IN     (RSTN_IN),
		.TICK_OUT    (osc_tick)
	);

	// Debug freeze stalls both prescaler and counter
	assign frozen   = DBG_FREEZE_IN & CORE_HALTED_IN;
	assign pre_wrap = (pre_q == PRESCALE_IN);

	// ----------------------------------------
	// State machine
	// ----------------------------------------
	// Low-power inputs are deliberately not used by the state machine: counting goes on
	always @* begin
		state_d = state_q;
		case (state_q)
			`IWD_ST_IDLE: begin
				if ((HW_START_OPT_IN && !opt_seen_q) || SW_START_IN)
					state_d = `IWD_ST_RUN;
			end
			`IWD_ST_RUN: begin
				if (osc_tick && pre_wrap && !frozen && !RELOAD_IN &&
				    COUNT_OUT == `IWD_CNT_ZERO + 12'h001)
					state_d = `IWD_ST_EXPIRED;
			end
			`IWD_ST_EXPIRED: begin
				if (!RESET_MODE_IN && RELOAD_IN)
					state_d = `IWD_ST_RUN;
			end
			default: state_d = `IWD_ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Prescaler and down counter
	// ----------------------------------------
	always @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			state_q           <= `IWD_ST_IDLE;
			opt_seen_q        <= 1'b0;
			pre_q             <= `IWD_PRE_ZERO;
			COUNT_OUT         <= `IWD_CNT_MAX;
			RUNNING_OUT       <= 1'b0;
			TIMEOUT_OUT       <= 1'b0;
			SYS_RESET_REQ_OUT <= 1'b0;
			STANDBY_WAKE_OUT  <= 1'b0;
		end else begin
			state_q     <= state_d;
			opt_seen_q  <= 1'b1; // Option sampled once after reset release
			RUNNING_OUT <= (state_d != `IWD_ST_IDLE);
			if (state_q == `IWD_ST_IDLE) begin
				pre_q     <= `IWD_PRE_ZERO;
				COUNT_OUT <= `IWD_CNT_MAX;
			end else if (RELOAD_IN) begin
				pre_q     <= `IWD_PRE_ZERO;
				COUNT_OUT <= RELOAD_VAL_IN;
			end else if (osc_tick && !frozen) begin
				if (pre_wrap) begin
					pre_q <= `IWD_PRE_ZERO;
					COUNT_OUT <= COUNT_OUT - 12'h001;
				end else begin
					pre_q <= pre_q + 8'h01;
				end
			end
			// Expiry handling: reset request or timeout flag, reload wins
			if (state_d == `IWD_ST_EXPIRED && state_q == `IWD_ST_RUN) begin
				TIMEOUT_OUT       <= 1'b1;
				SYS_RESET_REQ_OUT <= RESET_MODE_IN;
				STANDBY_WAKE_OUT  <= RESET_MODE_IN & STANDBY_MODE_IN;
			end else begin
				if (RELOAD_IN)
					TIMEOUT_OUT <= 1'b0;
				SYS_RESET_REQ_OUT <= 1'b0;
				STANDBY_WAKE_OUT  <= 1'b0;
			end
		end
	end

endmodule

// ---- iwd_defs.vh ----
`ifndef IWD_DEFS_VH
`define IWD_DEFS_VH

// ----------------------------------------
// Counter and prescaler geometry
// ----------------------------------------
`define IWD_CNT_W      12
`define IWD_PRE_W      8
`define IWD_CNT_MAX    12'hFFF
`define IWD_CNT_ZERO   12'h000
`define IWD_PRE_ZERO   8'h00
`define IWD_PRE_DEF    8'h03

// ----------------------------------------
// Oscillator tick derivation from core clock
// ----------------------------------------
`define IWD_CORE_HZ    200000000
`define IWD_OSC_HZ     40000
`define IWD_OSC_DIV    (`IWD_CORE_HZ / `IWD_OSC_HZ)
`define IWD_OSC_W      13
`define IWD_OSC_LAST   13'h1387

// ----------------------------------------
// Main state codes
// ----------------------------------------
`define IWD_ST_IDLE    2'h0
`define IWD_ST_RUN     2'h1
`define IWD_ST_EXPIRED 2'h2

`endif

// ---- iwd_lsi_osc.v ----
`timescale 1ns/10ps
`include "iwd_defs.vh"

// ----------------------------------------
// Low-speed oscillator tick model
// ----------------------------------------
module iwd_lsi_osc (
	// Clock and reset
	input  wire                  CORE_CLK_IN,
	input  wire                  RSTN_IN,
	// Tick output
	output reg                   TICK_OUT
);

	reg [`IWD_OSC_W-1:0] div_q;

	// Free-running 40 kHz tick, never gated by low-power state
	always @(posedge CORE_CLK_IN) begin
		if (!RSTN_IN) begin
			div_q    <= {`IWD_OSC_W{1'b0}};
			TICK_OUT <= 1'b0;
		end else if (div_q == `IWD_OSC_LAST) begin
			div_q    <= {`IWD_OSC_W{1'b0}};
			TICK_OUT <= 1'b1;
		end else begin
			div_q    <= div_q + 1'b1;
			TICK_OUT <= 1'b0;
		end
	end

endmodule

// ---- iwd_monitor.sv ----
`timescale 1ns/10ps
module iwd_monitor (
	input wire CORE_CLK_IN, RSTN_IN, HW_START_OPT_IN, RESET_MODE_IN, DBG_FREEZE_IN,
	input wire CORE_HALTED_IN, STOP_MODE_IN, STANDBY_MODE_IN, SW_START_IN, RELOAD_IN,
	input wire [11:0] RELOAD_VAL_IN,
	input wire [7:0] PRESCALE_IN,
	input wire [11:0] COUNT_OUT,
	input wire RUNNING_OUT, TIMEOUT_OUT, SYS_RESET_REQ_OUT, STANDBY_WAKE_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	rst_value_a: assert property (disable iff (1'b0) !RSTN_IN |=> COUNT_OUT == 12'hFFF)
		else $error("bad reset count");
	count_step_a: assert property ($changed(COUNT_OUT) && $past(RSTN_IN) &&
		!$past(RELOAD_IN) && !$past(SW_START_IN) |-> COUNT_OUT == $past(COUNT_OUT) - 12'h1)
		else $error("bad count step");
	reload_load_a: assert property (RELOAD_IN && RUNNING_OUT && !TIMEOUT_OUT
		|=> COUNT_OUT == $past(RELOAD_VAL_IN)) else $error("reload lost");
	freeze_hold_a: assert property ((DBG_FREEZE_IN && CORE_HALTED_IN && !RELOAD_IN)[*2]
		|=> $stable(COUNT_OUT)) else $error("count moved in freeze");
	run_start_a: assert property ($rose(RUNNING_OUT)
		|-> $past(SW_START_IN || HW_START_OPT_IN || RELOAD_IN)) else $error("bad start");
	timeout_zero_a: assert property ($rose(TIMEOUT_OUT) |-> COUNT_OUT == 12'h000)
		else $error("timeout not at zero");
	req_pulse_a: assert property (SYS_RESET_REQ_OUT |-> TIMEOUT_OUT && $past(RESET_MODE_IN)
		##1 !SYS_RESET_REQ_OUT) else $error("bad reset request");
	wake_req_a: assert property (STANDBY_WAKE_OUT |-> SYS_RESET_REQ_OUT)
		else $error("wake without reset");
endmodule
bind iwd_top iwd_monitor u_mon (.*);

// ---- test_iwd_top.sv ----
`timescale 1ns/10ps
module test_iwd_top;
	reg clk = 0, rstn = 0, hw = 0, md = 0, frz = 0, stb = 0, go = 0, rld = 0;
	reg [11:0] k;
	integer fail_count = 0, checks = 0, i, n;
	wire [11:0] cnt;
	wire run, tmo, req, wake;
	initial forever #2.5 clk = ~clk;
	iwd_top u_dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .HW_START_OPT_IN(hw), .RESET_MODE_IN(md),
		.DBG_FREEZE_IN(frz), .CORE_HALTED_IN(frz), .STOP_MODE_IN(1'b1), .STANDBY_MODE_IN(stb),
		.SW_START_IN(go), .RELOAD_IN(rld), .RELOAD_VAL_IN(12'h002), .PRESCALE_IN(8'h01),
		.COUNT_OUT(cnt), .RUNNING_OUT(run), .TIMEOUT_OUT(tmo), .SYS_RESET_REQ_OUT(req),
		.STANDBY_WAKE_OUT(wake));
	task summarize;
		begin
			$display("checks=%0d fail_count=%0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [11:0] g, input [11:0] e);
		begin
			checks = checks + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task rst(input h);
		begin
			rstn = 0;
			hw = h;
			repeat (10) @(negedge clk);
			rstn = 1;
			repeat (3) @(negedge clk);
		end
	endtask
	// Start, run to expiry, count pulses
	task t_expire(input m);
		begin
			md = m;
			stb = m;
			rst(0);
			go = 1;
			@(negedge clk);
			go = 0;
			rld = 1;
			chk(run, 1);
			@(negedge clk);
			rld = 0;
			chk(cnt, 12'h002);
			n = 0;
			for (i = 0; i < 21000 && !tmo; i = i + 1) begin
				@(negedge clk);
				n = n + req + wake;
			end
			chk(tmo, 1);
			if (!tmo)
				summarize;
			chk(cnt, 0);
			chk(n, m ? 2 : 0);
			rld = 1;
			@(negedge clk);
			rld = 0;
			@(negedge clk);
			chk(tmo, 0);
			$display("expire test done");
		end
	endtask
	// Hardware start, then freeze
	task t_freeze;
		begin
			md = 0;
			rst(1);
			chk(run, 1);
			frz = 1;
			repeat (2) @(negedge clk);
			k = cnt;
			repeat (11000) @(negedge clk);
			chk(cnt, k);
			frz = 0;
			repeat (10000) @(negedge clk);
			chk(cnt, k - 12'h001);
			$display("freeze test done");
		end
	endtask
	initial begin
		rst(0);
		chk(cnt, 12'hFFF);
		t_expire(1);
		t_expire(0);
		t_freeze;
		summarize;
	end
endmodule
